// ===== hdl/srp_regs.vh
// register map, field positions and codes for the strap, route and power control block
// assumes a 32-bit register bus with one aligned word per register
`ifndef SRP_REGS_VH
`define SRP_REGS_VH

// byte offsets
`define SRP_CTRL_OFS        8'h00
`define SRP_STATUS_OFS      8'h04
`define SRP_INT_STAT_OFS    8'h08
`define SRP_INT_CLR_OFS     8'h0C
`define SRP_INT_EN_OFS      8'h10

// control register fields
`define SRP_CTRL_EQ_OVR_EN   0
`define SRP_CTRL_LB_OVR_EN   1
`define SRP_CTRL_PIN_INT     2
`define SRP_CTRL_LB_SEL_LO   4
`define SRP_CTRL_EQ_CODE_LO  8
`define SRP_CTRL_RST         32'h0000_0000
`define SRP_CTRL_MASK        32'h0000_FF37

// status register fields
`define SRP_ST_SIG_DET      0
`define SRP_ST_MODE_LO      1
`define SRP_ST_LB_STRAP_LO  4
`define SRP_ST_SEC_STRAP_LO 6
`define SRP_ST_EQ_STRAP_LO  8
`define SRP_ST_EQ_CODE_LO   10
`define SRP_ST_MANUAL       18
`define SRP_ST_PIN_LEVEL    19

// interrupt event bits
`define SRP_EV_SIG_GAIN     0
`define SRP_EV_SIG_LOSS     1
`define SRP_EV_PWR_DOWN     2
`define SRP_EV_W            3
`define SRP_INT_EN_RST      3'h0

// decoded four-level strap states
`define SRP_LVL_L           2'h0
`define SRP_LVL_R           2'h1
`define SRP_LVL_F           2'h2
`define SRP_LVL_H           2'h3

// comparator thermometer codes {above 0.8, above 0.5, above 0.2}
`define SRP_THERM_L         3'h0
`define SRP_THERM_R         3'h1
`define SRP_THERM_F         3'h3
`define SRP_THERM_H         3'h7

// equalizer boost codes
`define SRP_EQ_CODE_HF      8'h00
`define SRP_EQ_CODE_R       8'h80
`define SRP_EQ_CODE_L       8'h90

// bus responses
`define SRP_RESP_OKAY       2'h0
`define SRP_RESP_SLVERR     2'h2

`endif

// ===== hdl/srp_sync3.v
// three-stage synchroniser with agreement filter for a group of pin levels
// assumes clk is the control clock; d may change at any time
`timescale 1ns/1ps

module srp_sync3 #(
	parameter W   = 1,
	parameter RST = 0
) (
	input  wire         clk,
	input  wire         resetn,
	input  wire [W-1:0] d,
	output reg  [W-1:0] q
);
	reg [W-1:0] ff1_r;
	reg [W-1:0] ff2_r;
	reg [W-1:0] ff3_r;

	// first stage feeds only the second; q moves once stages two and three agree
	always @(posedge clk) begin
		if (!resetn) begin
			ff1_r <= RST[W-1:0];
			ff2_r <= RST[W-1:0];
			ff3_r <= RST[W-1:0];
			q     <= RST[W-1:0];
		end else begin
			ff1_r <= d;
			ff2_r <= ff1_r;
			ff3_r <= ff2_r;
			if (ff2_r == ff3_r) begin
				q <= ff3_r;
			end
		end
	end
endmodule

// ===== hdl/srp_ctrl.v
// strap decode, output routing, equalizer code and power-mode control with register access
// assumes strap comparators and the signal detector arrive as asynchronous pin levels
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "srp_regs.vh"

module srp_ctrl #(
	parameter ADDR_W = 8
) (
	input  wire              clk,
	input  wire              resetn,
	// register bus
	input  wire [ADDR_W-1:0] awaddr,
	input  wire [2:0]        awprot,
	input  wire              awvalid,
	output wire              awready,
	input  wire [31:0]       wdata,
	input  wire [3:0]        wstrb,
	input  wire              wvalid,
	output wire              wready,
	output reg  [1:0]        bresp,
	output reg               bvalid,
	input  wire              bready,
	input  wire [ADDR_W-1:0] araddr,
	input  wire [2:0]        arprot,
	input  wire              arvalid,
	output wire              arready,
	output reg  [31:0]       rdata,
	output reg  [1:0]        rresp,
	output reg               rvalid,
	input  wire              rready,
	// strap comparators {above 0.8, above 0.5, above 0.2}
	input  wire [2:0]        loopRouteSelCmp,
	input  wire [2:0]        secondaryOutSelCmp,
	input  wire [2:0]        inputEqStrapCmp,
	// enable pin and host input detector
	input  wire              enablePin,
	input  wire              hostInputDetect,
	// open-drain active-low signal detect pin
	input  wire              sigDetectNIn,
	output reg               sigDetectNOut,
	output reg               sigDetectNOe,
	// path and analog controls
	output reg               primaryCableOutEn,
	output reg               secondaryCableOutEn,
	output reg               loopbackOutEn,
	output reg               inputEqualizerEn,
	output reg               sigDetectorEn,
	output reg  [7:0]        inputEqBoost,
	output reg               manualAdaptMode,
	output reg  [1:0]        loopbackLevelSel,
	output wire              irq
);
	// power states, one-hot
	localparam [2:0] ST_DOWN   = 3'h1;
	localparam [2:0] ST_SAVE   = 3'h2;
	localparam [2:0] ST_NORMAL = 3'h4;

	wire [2:0] loopCmp;
	wire [2:0] secCmp;
	wire [2:0] eqCmp;
	wire       enSync;
	wire       detSync;
	wire       pinLevel;

	reg  [2:0]        pwrState_r;
	reg  [2:0]        pwrState_nxt;
	reg  [31:0]       ctrl_r;
	reg  [`SRP_EV_W-1:0] intStat_r;
	reg  [`SRP_EV_W-1:0] intEn_r;
	reg  [`SRP_EV_W-1:0] intClr;
	reg               sigDet_r;
	reg               awHeld_r;
	reg               wHeld_r;
	reg  [ADDR_W-1:0] awAddr_r;
	reg  [31:0]       wData_r;
	reg  [3:0]        wStrb_r;
	reg  [31:0]       rdNxt;
	reg  [1:0]        rrNxt;
	reg  [1:0]        wrResp;

	// three-flop sync of all pins that steer the modes
	srp_sync3 #(.W(9), .RST({`SRP_THERM_F, `SRP_THERM_F, `SRP_THERM_F})) uStrapSync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({loopRouteSelCmp, secondaryOutSelCmp, inputEqStrapCmp}),
		.q      ({loopCmp, secCmp, eqCmp})
	);
	srp_sync3 #(.W(3), .RST(3'h1)) uPinSync (
		.clk    (clk),
		.resetn (resetn),
		.d      ({enablePin, hostInputDetect, sigDetectNIn}),
		.q      ({enSync, detSync, pinLevel})
	);

	// thermometer to level; broken codes read as float, the open-pin level
	function [1:0] decodeStrap;
		input [2:0] cmp;
		case (cmp)
			`SRP_THERM_L: decodeStrap = `SRP_LVL_L;
			`SRP_THERM_R: decodeStrap = `SRP_LVL_R;
			`SRP_THERM_F: decodeStrap = `SRP_LVL_F;
			`SRP_THERM_H: decodeStrap = `SRP_LVL_H;
			default:      decodeStrap = `SRP_LVL_F;
		endcase
	endfunction

	wire [1:0] loopLvl = decodeStrap(loopCmp);
	wire [1:0] secLvl  = decodeStrap(secCmp);
	wire [1:0] eqLvl   = decodeStrap(eqCmp);

	// strap-derived boost, fixed per level
	reg [7:0] strapBoost;
	always @* begin
		case (eqLvl)
			`SRP_LVL_L: strapBoost = `SRP_EQ_CODE_L;
			`SRP_LVL_R: strapBoost = `SRP_EQ_CODE_R;
			default:    strapBoost = `SRP_EQ_CODE_HF;
		endcase
	end

	wire       eqOvrEn = ctrl_r[`SRP_CTRL_EQ_OVR_EN];
	wire       lbOvrEn = ctrl_r[`SRP_CTRL_LB_OVR_EN];
	wire       pinInt  = ctrl_r[`SRP_CTRL_PIN_INT];
	wire [7:0] ovrCode = ctrl_r[`SRP_CTRL_EQ_CODE_LO +: 8];
	wire [1:0] ovrLb   = ctrl_r[`SRP_CTRL_LB_SEL_LO +: 2];
	wire [7:0] boostSel = eqOvrEn ? ovrCode : strapBoost;
	wire [1:0] lbSel    = lbOvrEn ? ovrLb : eqLvl;

	// detector output is meaningless while powered down, so it is masked there
	wire detValid = detSync & (pwrState_r != ST_DOWN);

	// power mode sequencing
	always @* begin
		case (pwrState_r)
			ST_DOWN:
				pwrState_nxt = enSync ? ST_SAVE : ST_DOWN;
			ST_SAVE:
				if (!enSync)
					pwrState_nxt = ST_DOWN;
				else if (detSync)
					pwrState_nxt = ST_NORMAL;
				else
					pwrState_nxt = ST_SAVE;
			ST_NORMAL:
				if (!enSync)
					pwrState_nxt = ST_DOWN;
				else if (!detSync)
					pwrState_nxt = ST_SAVE;
				else
					pwrState_nxt = ST_NORMAL;
			default:
				pwrState_nxt = ST_DOWN;
		endcase
	end

	// state, detect history and the open-drain pin, low on detect, or on irq when the pin interrupt bit is set
	always @(posedge clk) begin
		if (!resetn) begin
			pwrState_r    <= ST_DOWN;
			sigDet_r      <= 1'b0;
			sigDetectNOut <= 1'b0;
			sigDetectNOe  <= 1'b0;
		end else begin
			pwrState_r    <= pwrState_nxt;
			sigDet_r      <= detValid;
			sigDetectNOut <= 1'b0; // the pin only ever pulls low
			sigDetectNOe  <= pinInt ? irq : detValid;
		end
	end

	// registered path and analog controls
	always @(posedge clk) begin
		if (!resetn) begin
			primaryCableOutEn   <= 1'b0;
			secondaryCableOutEn <= 1'b0;
			loopbackOutEn       <= 1'b0;
			inputEqualizerEn    <= 1'b0;
			sigDetectorEn       <= 1'b0;
			inputEqBoost        <= `SRP_EQ_CODE_HF;
			manualAdaptMode     <= 1'b1;
			loopbackLevelSel    <= `SRP_LVL_F;
		end else begin
			// primary follows the data path alone, no strap gates it
			primaryCableOutEn   <= pwrState_nxt == ST_NORMAL;
			secondaryCableOutEn <= (pwrState_nxt == ST_NORMAL) && (secLvl == `SRP_LVL_L);
			loopbackOutEn       <= (pwrState_nxt == ST_NORMAL) && (loopLvl == `SRP_LVL_L);
			inputEqualizerEn    <= pwrState_nxt == ST_NORMAL;
			sigDetectorEn       <= pwrState_nxt != ST_DOWN;
			inputEqBoost        <= boostSel;
			manualAdaptMode     <= 1'b1;
			loopbackLevelSel    <= lbSel;
		end
	end

	// interrupt events and sticky status; set beats a same-cycle clear
	wire [`SRP_EV_W-1:0] events;
	assign events[`SRP_EV_SIG_GAIN] = detValid & ~sigDet_r;
	assign events[`SRP_EV_SIG_LOSS] = ~detValid & sigDet_r;
	assign events[`SRP_EV_PWR_DOWN] = (pwrState_nxt == ST_DOWN) & (pwrState_r != ST_DOWN);
	assign irq = |(intStat_r & intEn_r);

	// write channel: address and data taken in either order
	wire awFire = awvalid & awready;
	wire wFire  = wvalid & wready;
	assign awready = ~awHeld_r & ~bvalid;
	assign wready  = ~wHeld_r & ~bvalid;
	wire              awHave = awHeld_r | awFire;
	wire              wHave  = wHeld_r | wFire;
	wire [ADDR_W-1:0] wrAddr = awHeld_r ? awAddr_r : awaddr;
	wire [31:0]       wrData = wHeld_r ? wData_r : wdata;
	wire [3:0]        wrStrb = wHeld_r ? wStrb_r : wstrb;
	wire              doWrite = awHave & wHave & ~bvalid;

	// byte-lane merge of a write into a stored word
	function [31:0] mergeBytes;
		input [31:0] old;
		input [31:0] din;
		input [3:0]  strb;
		integer i;
		begin
			mergeBytes = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					mergeBytes[i*8 +: 8] = din[i*8 +: 8];
			end
		end
	endfunction

	wire [31:0] clrWord = mergeBytes(32'h0000_0000, wrData, wrStrb);
	wire [31:0] enWord  = mergeBytes({29'h0, intEn_r}, wrData, wrStrb);
	wire [31:0] ctlWord = mergeBytes(ctrl_r, wrData, wrStrb) & `SRP_CTRL_MASK;

	// write decode; read-only and unmapped offsets answer with an error
	always @* begin
		intClr = {`SRP_EV_W{1'b0}};
		wrResp = `SRP_RESP_OKAY;
		case (wrAddr)
			`SRP_CTRL_OFS:    wrResp = `SRP_RESP_OKAY;
			`SRP_INT_EN_OFS:  wrResp = `SRP_RESP_OKAY;
			`SRP_INT_CLR_OFS: intClr = doWrite ? clrWord[`SRP_EV_W-1:0] : {`SRP_EV_W{1'b0}};
			default:          wrResp = `SRP_RESP_SLVERR;
		endcase
	end

	always @(posedge clk) begin
		if (!resetn) begin
			awHeld_r  <= 1'b0;
			wHeld_r   <= 1'b0;
			awAddr_r  <= {ADDR_W{1'b0}};
			wData_r   <= 32'h0000_0000;
			wStrb_r   <= 4'h0;
			bvalid    <= 1'b0;
			bresp     <= `SRP_RESP_OKAY;
			ctrl_r    <= `SRP_CTRL_RST;
			intEn_r   <= `SRP_INT_EN_RST;
			intStat_r <= {`SRP_EV_W{1'b0}};
		end else begin
			intStat_r <= (intStat_r & ~intClr) | events;
			if (doWrite) begin
				awHeld_r <= 1'b0;
				wHeld_r  <= 1'b0;
				bvalid   <= 1'b1;
				bresp    <= wrResp;
				if (wrAddr == `SRP_CTRL_OFS)
					ctrl_r <= ctlWord;
				if (wrAddr == `SRP_INT_EN_OFS)
					intEn_r <= enWord[`SRP_EV_W-1:0];
			end else begin
				if (awFire) begin
					awHeld_r <= 1'b1;
					awAddr_r <= awaddr;
				end
				if (wFire) begin
					wHeld_r <= 1'b1;
					wData_r <= wdata;
					wStrb_r <= wstrb;
				end
				if (bvalid && bready)
					bvalid <= 1'b0;
			end
		end
	end

	// read decode
	always @* begin
		rdNxt = 32'h0000_0000;
		rrNxt = `SRP_RESP_OKAY;
		case (araddr)
			`SRP_CTRL_OFS:     rdNxt = ctrl_r;
			`SRP_STATUS_OFS: begin
				rdNxt[`SRP_ST_SIG_DET]           = sigDet_r;
				rdNxt[`SRP_ST_MODE_LO +: 3]      = pwrState_r;
				rdNxt[`SRP_ST_LB_STRAP_LO +: 2]  = loopLvl;
				rdNxt[`SRP_ST_SEC_STRAP_LO +: 2] = secLvl;
				rdNxt[`SRP_ST_EQ_STRAP_LO +: 2]  = eqLvl;
				rdNxt[`SRP_ST_EQ_CODE_LO +: 8]   = inputEqBoost;
				rdNxt[`SRP_ST_MANUAL]            = manualAdaptMode;
				rdNxt[`SRP_ST_PIN_LEVEL]         = pinLevel;
			end
			`SRP_INT_STAT_OFS: rdNxt[`SRP_EV_W-1:0] = intStat_r;
			`SRP_INT_EN_OFS:   rdNxt[`SRP_EV_W-1:0] = intEn_r;
			`SRP_INT_CLR_OFS:  rdNxt = 32'h0000_0000;
			default:           rrNxt = `SRP_RESP_SLVERR;
		endcase
	end

	// read channel: one read in flight, answered the cycle after it is taken
	assign arready = ~rvalid;
	always @(posedge clk) begin
		if (!resetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= `SRP_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rdNxt;
			rresp  <= rrNxt;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule

// ===== tb/srp_ctrl_sva.sv
// concurrent checks on the strap, route and power control ports
// assumes the pin is put in interrupt mode only while the input is idle
`timescale 1ns/1ps

module srp_ctrl_sva (
	input logic        clk,
	input logic        resetn,
	input logic        awvalid,
	input logic        awready,
	input logic        wvalid,
	input logic        wready,
	input logic [1:0]  bresp,
	input logic        bvalid,
	input logic        bready,
	input logic [31:0] rdata,
	input logic        rvalid,
	input logic        rready,
	input logic        enablePin,
	input logic        hostInputDetect,
	input logic        sigDetectNOut,
	input logic        sigDetectNOe,
	input logic        primaryCableOutEn,
	input logic        secondaryCableOutEn,
	input logic        loopbackOutEn,
	input logic        inputEqualizerEn,
	input logic        sigDetectorEn,
	input logic        manualAdaptMode
);
	// pin windows of 7 or 8 cycles cover the sync and state latency
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	sec_route_a: assert property (secondaryCableOutEn |-> primaryCableOutEn)
		else $error("secondary output on outside normal mode");
	loop_route_a: assert property (loopbackOutEn |-> primaryCableOutEn)
		else $error("loopback output on outside normal mode");
	adapt_mode_a: assert property (manualAdaptMode)
		else $error("equalizer left manual mode");
	pwr_down_a: assert property (!enablePin [*7] |-> !primaryCableOutEn && !inputEqualizerEn && !sigDetectNOe)
		else $error("path alive with enable low");
	pwr_save_a: assert property ((enablePin && !hostInputDetect) [*7] |-> !primaryCableOutEn && sigDetectorEn)
		else $error("power save state wrong");
	normal_mode_a: assert property ((enablePin && hostInputDetect) [*8] |-> primaryCableOutEn && inputEqualizerEn && sigDetectorEn)
		else $error("normal mode not reached");
	detect_pin_a: assert property ((enablePin && hostInputDetect) [*8] |-> sigDetectNOe && !sigDetectNOut)
		else $error("detect pin not pulled low");
	wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	wr_answer_a: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("write response late");
endmodule

// ===== tb/srp_host_model.sv
// far-side model: host serializer activity seen by the detector, pulled-up pin
// assumes sigOn is the bench's command for signal present
`timescale 1ns/1ps

module srp_host_model (
	input  logic clk,
	input  logic sigOn,
	input  logic sigDetectNOe,
	input  logic sigDetectNOut,
	output logic hostInputDetect = 1'b0,
	output logic sigDetectNIn
);
	// detector lags the serializer by one clock
	always @(posedge clk) hostInputDetect <= sigOn;
	// open drain with pull-up: released pin reads high
	assign sigDetectNIn = sigDetectNOe ? sigDetectNOut : 1'b1;
endmodule

// ===== tb/srp_ctrl_tb.sv
// bench for the strap, route and power block with queued bus answer checks
// assumes one 25 ns clock and the far-side model in srp_host_model
`timescale 1ns/1ps
`include "srp_regs.vh"

module srp_ctrl_tb;
	logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready, enablePin, sigOn;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, d;
	logic [2:0]  loopRouteSelCmp, secondaryOutSelCmp, inputEqStrapCmp;
	wire         awready, wready, bvalid, arready, rvalid, hostInputDetect, sigDetectNIn;
	wire         sigDetectNOut, sigDetectNOe, primaryCableOutEn, secondaryCableOutEn;
	wire         loopbackOutEn, inputEqualizerEn, sigDetectorEn, manualAdaptMode, irq;
	wire  [1:0]  bresp, rresp, loopbackLevelSel;
	wire  [31:0] rdata;
	wire  [7:0]  inputEqBoost;
	logic [33:0] wrQ[$], rdQ[$];
	logic [2:0]  thr[5] = '{`SRP_THERM_L, `SRP_THERM_R, `SRP_THERM_F, `SRP_THERM_H, 3'h2};
	logic [1:0]  lvl[5] = '{`SRP_LVL_L, `SRP_LVL_R, `SRP_LVL_F, `SRP_LVL_H, `SRP_LVL_F};
	integer      err_total = 0, comparisons = 0, seed = 66552;

	srp_ctrl u_dut (.clk, .resetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
		.wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0),
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .loopRouteSelCmp,
		.secondaryOutSelCmp, .inputEqStrapCmp, .enablePin, .hostInputDetect, .sigDetectNIn,
		.sigDetectNOut, .sigDetectNOe, .primaryCableOutEn, .secondaryCableOutEn,
		.loopbackOutEn, .inputEqualizerEn, .sigDetectorEn, .inputEqBoost, .manualAdaptMode,
		.loopbackLevelSel, .irq);
	srp_host_model u_host (.clk, .sigOn, .sigDetectNOe, .sigDetectNOut, .hostInputDetect,
		.sigDetectNIn);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input [33:0] seen, input [33:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// let pin syncs, the mode step and the pin's loop back through its sync land
	task automatic settle;
		repeat (12) @(posedge clk);
		#1;
	endtask

	// write with a random late bready; answer checked by the monitor
	task automatic wr(input [7:0] a, input [31:0] v, input [1:0] r);
		int n, dly;
		logic done;
		n = 0;
		dly = $unsigned($random(seed)) % 3;
		wrQ.push_back({r, 32'h0});
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			done = bvalid && bready;
			bready <= !done && n > dly; // one assignment per edge
		end while (!done && n < 50);
		if (!done) err_total++;
	endtask

	task automatic rd(input [7:0] a, input [31:0] v, input [1:0] r);
		int n, dly;
		logic done;
		n = 0;
		dly = $unsigned($random(seed)) % 3;
		rdQ.push_back({r, v});
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
			done = rvalid && rready;
			rready <= !done && n > dly; // one assignment per edge
		end while (!done && n < 50);
		if (!done) err_total++;
	endtask

	function automatic [7:0] boostOf(input [1:0] l);
		boostOf = (l == `SRP_LVL_L) ? `SRP_EQ_CODE_L : (l == `SRP_LVL_R) ? `SRP_EQ_CODE_R : `SRP_EQ_CODE_HF;
	endfunction

	function automatic [31:0] stat(input [1:0] lp, sc, eq, input [7:0] b, input [2:0] md,
		input det, pin);
		stat = {12'h000, pin, 1'b1, b, eq, sc, lp, md, det};
	endfunction

	// oldest note against each bus answer
	always @(posedge clk) begin
		if (bvalid && bready) chk({bresp, 32'h0}, wrQ.pop_front());
		if (rvalid && rready) chk({rresp, rdata}, rdQ.pop_front());
	end

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		close_out;
	end

	initial begin
		{resetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
		enablePin = 1'b1;
		sigOn = 1'b1;
		loopRouteSelCmp = `SRP_THERM_F;
		secondaryOutSelCmp = `SRP_THERM_F;
		inputEqStrapCmp = `SRP_THERM_F;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		settle;
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			loopRouteSelCmp <= thr[i];
			secondaryOutSelCmp <= thr[(i + 2) % 5];
			inputEqStrapCmp <= thr[i];
			settle;
			chk(primaryCableOutEn, 1'b1);
			chk(loopbackOutEn, lvl[i] == `SRP_LVL_L);
			chk(secondaryCableOutEn, lvl[(i + 2) % 5] == `SRP_LVL_L);
			chk(inputEqBoost, boostOf(lvl[i]));
			chk(loopbackLevelSel, lvl[i]);
			chk(sigDetectNOe, 1'b1);
			rd(`SRP_STATUS_OFS, stat(lvl[i], lvl[(i + 2) % 5], lvl[i], boostOf(lvl[i]), 3'h4, 1, 0), `SRP_RESP_OKAY);
		end
		wr(`SRP_INT_CLR_OFS, 32'h7, `SRP_RESP_OKAY);
		wr(`SRP_INT_EN_OFS, 32'h3, `SRP_RESP_OKAY);
		settle;
		chk(irq, 1'b0);
		sigOn <= 1'b0;
		settle;
		chk(primaryCableOutEn, 1'b0);
		chk(irq, 1'b1);
		rd(`SRP_STATUS_OFS, stat(2, 1, 2, 8'h00, 3'h2, 0, 1), `SRP_RESP_OKAY);
		rd(`SRP_INT_STAT_OFS, 32'h2, `SRP_RESP_OKAY);
		wr(`SRP_INT_EN_OFS, 32'h1, `SRP_RESP_OKAY);
		settle;
		chk(irq, 1'b0);
		wr(`SRP_INT_CLR_OFS, 32'h2, `SRP_RESP_OKAY);
		rd(`SRP_INT_STAT_OFS, 32'h0, `SRP_RESP_OKAY);
		sigOn <= 1'b1;
		settle;
		chk(primaryCableOutEn, 1'b1);
		chk(irq, 1'b1);
		rd(`SRP_INT_STAT_OFS, 32'h1, `SRP_RESP_OKAY);
		wr(`SRP_INT_CLR_OFS, 32'h1, `SRP_RESP_OKAY);
		enablePin <= 1'b0;
		settle;
		chk({primaryCableOutEn, sigDetectNOe}, 2'b00);
		rd(`SRP_STATUS_OFS, stat(2, 1, 2, 8'h00, 3'h1, 0, 1), `SRP_RESP_OKAY);
		enablePin <= 1'b1;
		d = $random(seed);
		wr(`SRP_CTRL_OFS, {16'h0, d[15:8], 2'h0, d[5:4], 4'h3}, `SRP_RESP_OKAY);
		settle;
		chk(inputEqBoost, d[15:8]);
		chk(loopbackLevelSel, d[5:4]);
		rd(`SRP_CTRL_OFS, {16'h0, d[15:8], 2'h0, d[5:4], 4'h3}, `SRP_RESP_OKAY);
		rd(`SRP_STATUS_OFS, stat(2, 1, 2, d[15:8], 3'h4, 1, 0), `SRP_RESP_OKAY);
		wr(`SRP_STATUS_OFS, d, `SRP_RESP_SLVERR);
		rd(8'h20, 32'h0, `SRP_RESP_SLVERR);
		rd(`SRP_INT_CLR_OFS, 32'h0, `SRP_RESP_OKAY);
		// pin in interrupt mode while the input is idle; gain event is still pending
		sigOn <= 1'b0;
		wr(`SRP_CTRL_OFS, {16'h0, d[15:8], 2'h0, d[5:4], 4'h7}, `SRP_RESP_OKAY);
		settle;
		chk(sigDetectNOe, 1'b1);
		wr(`SRP_INT_CLR_OFS, 32'h7, `SRP_RESP_OKAY);
		settle;
		chk({irq, sigDetectNOe}, 2'b00);
		close_out;
	end
endmodule

bind srp_ctrl srp_ctrl_sva u_sva (.clk, .resetn, .awvalid, .awready, .wvalid, .wready, .bresp,
	.bvalid, .bready, .rdata, .rvalid, .rready, .enablePin, .hostInputDetect, .sigDetectNOut,
	.sigDetectNOe, .primaryCableOutEn, .secondaryCableOutEn, .loopbackOutEn, .inputEqualizerEn,
	.sigDetectorEn, .manualAdaptMode);
